//--- rtl/qcf_pkg.sv
package qcf_pkg;
  // register byte offsets
  localparam logic [11:0] QCF_OFF_GRAD    = 12'h000;
  localparam logic [11:0] QCF_OFF_COOLTH  = 12'h004;
  localparam logic [11:0] QCF_OFF_PWMTH   = 12'h008;
  localparam logic [11:0] QCF_OFF_FSTH    = 12'h00c;
  localparam logic [11:0] QCF_OFF_PWMCFG  = 12'h010;
  localparam logic [11:0] QCF_OFF_STBY    = 12'h014;
  localparam logic [11:0] QCF_OFF_PDDLY   = 12'h018;
  localparam logic [11:0] QCF_OFF_VEL     = 12'h01c;
  localparam logic [11:0] QCF_OFF_STATUS  = 12'h020;
  // field layout
  localparam int QCF_GRAD_W    = 4;
  localparam int QCF_SPD_W     = 24;
  localparam int QCF_FREQ_W    = 2;
  localparam int QCF_FREQ_LSB  = 0;
  localparam int QCF_ASCL_BIT  = 2;
  localparam int QCF_SSM_LSB   = 4;
  localparam int QCF_CUR_W     = 8;
  localparam int QCF_PDD_W     = 8;
  // reset values
  localparam logic [3:0]  QCF_GRAD_RST   = 4'h0;
  localparam logic [23:0] QCF_COOLTH_RST = 24'h000000;
  localparam logic [23:0] QCF_PWMTH_RST  = 24'h000000;
  localparam logic [23:0] QCF_FSTH_RST   = 24'hffffff;
  localparam logic [1:0]  QCF_FREQ_RST   = 2'h1;
  localparam logic        QCF_ASCL_RST   = 1'b1;
  localparam logic [1:0]  QCF_SSM_RST    = 2'h0;
  localparam logic [7:0]  QCF_STBY_RST   = 8'h00;
  localparam logic [7:0]  QCF_PDD_RST    = 8'hc8;
  localparam logic [3:0]  QCF_GRAD_MAX   = 4'hf;
  // timing
  localparam int QCF_CLK_HZ      = 20000000;
  localparam int QCF_PD_UNIT_MS  = 10;
  localparam int QCF_PD_UNIT_CYC = QCF_CLK_HZ / 1000 * QCF_PD_UNIT_MS;
  localparam int QCF_TICK_W      = 18;

  typedef enum logic [1:0] {
    QCF_SS_STBY   = 2'b00,
    QCF_SS_FREE   = 2'b01,
    QCF_SS_LSHORT = 2'b10,
    QCF_SS_HSHORT = 2'b11
  } qcf_ssm_t;

  typedef enum logic [1:0] {
    QCF_COIL_RUN   = 2'b00,
    QCF_COIL_OPEN  = 2'b01,
    QCF_COIL_LSHRT = 2'b10,
    QCF_COIL_HSHRT = 2'b11
  } qcf_coil_t;
endpackage

//--- rtl/qcf_tick.sv
`timescale 1ns/10ps
// one-cycle enable every DIV clocks
module qcf_tick #(
  parameter int DIV = 200000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  logic [qcf_pkg::QCF_TICK_W-1:0] cnt_r;
  wire                            wrap = (cnt_r ==
    qcf_pkg::QCF_TICK_W'(DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= wrap ? '0 : cnt_r + 1'b1;
      tick  <= wrap;
    end
  end
endmodule

//--- rtl/qcf_select.sv
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - a zero gradient setting, the reset value, keeps the quiet chopper off.
// - gradient values 0..15 are accepted, larger writes saturate at 15.
// - quiet mode needs speed below the energy-saving and pwm thresholds.
// - speed must also be below the fullstep threshold, reset 16777215.
// - mode follows the speed conditions both ways with no software action.
// - a read-only status flag shows the quiet chopper in use.
// - quiet pwm frequency comes from its own frequency-select field.
// - automatic current scaling enable exists and is set after reset.
// - standstill mode 0 lowers current to the standby current at rest.
// - standstill mode 1 opens both coils at rest.
// - standstill mode 2 shorts coils via low-side drivers at rest.
// - standstill mode 3 shorts coils via high-side drivers at rest.
// - modes 1..3 apply only with quiet mode on and standby current zero.
// - standstill is declared after the power-down delay in 10 ms units.
module qcf_select #(
  // one power-down delay unit in clocks; only a bench shortens it
  parameter int PD_UNIT_CYC = qcf_pkg::QCF_PD_UNIT_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             quiet_on,
  output logic      [1:0]  pwm_freq,
  output logic             pwm_autoscale,
  output logic      [3:0]  pwm_grad,
  output logic      [1:0]  coil_state,
  output logic      [7:0]  coil_cur_lim,
  output logic             standstill
);
  localparam int SW = qcf_pkg::QCF_SPD_W;

  // configuration and state registers
  logic [3:0]    grad_r;
  logic [SW-1:0] coolth_r;
  logic [SW-1:0] pwmth_r;
  logic [SW-1:0] fsth_r;
  logic [1:0]    freq_r;
  logic          ascl_r;
  logic [1:0]    ssm_r;
  logic [7:0]    run_cur_r;
  logic [7:0]    stby_r;
  logic [7:0]    pdd_r;
  logic [31:0]   vel_r;
  logic          vel_upd_r;
  logic          cfg_upd_r;
  logic          quiet_r;
  logic [7:0]    pd_cnt_r;
  logic          stand_r;

  // apb decode
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire sel_grad = (paddr == qcf_pkg::QCF_OFF_GRAD);
  wire sel_cool = (paddr == qcf_pkg::QCF_OFF_COOLTH);
  wire sel_pwmt = (paddr == qcf_pkg::QCF_OFF_PWMTH);
  wire sel_fsth = (paddr == qcf_pkg::QCF_OFF_FSTH);
  wire sel_cfg  = (paddr == qcf_pkg::QCF_OFF_PWMCFG);
  wire sel_stby = (paddr == qcf_pkg::QCF_OFF_STBY);
  wire sel_pdd  = (paddr == qcf_pkg::QCF_OFF_PDDLY);
  wire sel_vel  = (paddr == qcf_pkg::QCF_OFF_VEL);
  wire sel_sts  = (paddr == qcf_pkg::QCF_OFF_STATUS);
  wire mapped   = sel_grad | sel_cool | sel_pwmt | sel_fsth | sel_cfg |
                  sel_stby | sel_pdd | sel_vel | sel_sts;

  // saturate rather than wrap so 16+ still means quiet-enabled
  wire [3:0] grad_nxt = (pwdata[31:4] != 28'h0) ? qcf_pkg::QCF_GRAD_MAX
                        : pwdata[3:0];

  wire [31:0] rd_mux =
      sel_grad ? {28'h0, grad_r}
    : sel_cool ? {8'h0, coolth_r}
    : sel_pwmt ? {8'h0, pwmth_r}
    : sel_fsth ? {8'h0, fsth_r}
    : sel_cfg  ? {26'h0, ssm_r, 1'b0, ascl_r, freq_r}
    : sel_stby ? {16'h0, run_cur_r, stby_r}
    : sel_pdd  ? {24'h0, pdd_r}
    : sel_vel  ? vel_r
    : sel_sts  ? {30'h0, stand_r, quiet_r}
    : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // single wait state: answer lands in the second access cycle
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      prdata  <= (acc & ~pready & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  wire wr_go = wr & pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grad_r    <= qcf_pkg::QCF_GRAD_RST;
      coolth_r  <= qcf_pkg::QCF_COOLTH_RST;
      pwmth_r   <= qcf_pkg::QCF_PWMTH_RST;
      fsth_r    <= qcf_pkg::QCF_FSTH_RST;
      freq_r    <= qcf_pkg::QCF_FREQ_RST;
      ascl_r    <= qcf_pkg::QCF_ASCL_RST;
      ssm_r     <= qcf_pkg::QCF_SSM_RST;
      run_cur_r <= 8'hff;
      stby_r    <= qcf_pkg::QCF_STBY_RST;
      pdd_r     <= qcf_pkg::QCF_PDD_RST;
    end else if (wr_go) begin
      if (sel_grad) grad_r <= grad_nxt;
      if (sel_cool) coolth_r <= pwdata[SW-1:0];
      if (sel_pwmt) pwmth_r <= pwdata[SW-1:0];
      if (sel_fsth) fsth_r <= pwdata[SW-1:0];
      if (sel_cfg) begin
        freq_r <= pwdata[1:0];
        ascl_r <= pwdata[qcf_pkg::QCF_ASCL_BIT];
        ssm_r  <= pwdata[5:4];
      end
      if (sel_stby) begin
        stby_r    <= pwdata[7:0];
        run_cur_r <= pwdata[15:8];
      end
      if (sel_pdd) pdd_r <= pwdata[7:0];
    end
  end

  // velocity comes from the ramp generator via software here; each write
  // counts as one velocity update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vel_r     <= 32'h0;
      vel_upd_r <= 1'b0;
      cfg_upd_r <= 1'b0;
    end else begin
      vel_upd_r <= wr_go & sel_vel;
      cfg_upd_r <= wr_go;
      if (wr_go & sel_vel) vel_r <= pwdata;
    end
  end

  // absolute speed, clipped to threshold width
  wire [31:0]   vel_abs = vel_r[31] ? (~vel_r + 32'h1) : vel_r;
  wire [SW-1:0] spd     = (vel_abs[31:SW] != '0) ? {SW{1'b1}}
                          : vel_abs[SW-1:0];
  wire below_cool = spd < coolth_r;
  wire below_pwm  = spd < pwmth_r;
  wire below_fs   = spd < fsth_r;
  wire quiet_nxt  = (grad_r != 4'h0) & below_cool & below_pwm & below_fs;

  // re-evaluated the cycle after any write, once the new value is stored;
  // the write edge itself would still see the old settings
  wire reeval = vel_upd_r | cfg_upd_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_r <= 1'b0;
    else if (reeval) quiet_r <= quiet_nxt;
  end

  // power-down delay: 10 ms ticks after motion ends
  logic tick10;
  qcf_tick #(.DIV(PD_UNIT_CYC)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick10)
  );

  wire moving = (vel_r != 32'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_cnt_r <= 8'h0;
      stand_r  <= 1'b0;
    end else if (moving) begin
      pd_cnt_r <= 8'h0;
      stand_r  <= 1'b0;
    end else if (!stand_r && tick10) begin
      if (pd_cnt_r >= pdd_r) stand_r <= 1'b1;
      else pd_cnt_r <= pd_cnt_r + 8'h1;
    end
  end

  // standstill coil condition
  wire ss_ok = quiet_r & (stby_r == 8'h0);
  qcf_pkg::qcf_coil_t coil_nxt;
  always_comb begin
    coil_nxt = qcf_pkg::QCF_COIL_RUN;
    if (stand_r && ss_ok) begin
      case (qcf_pkg::qcf_ssm_t'(ssm_r))
        qcf_pkg::QCF_SS_FREE:   coil_nxt = qcf_pkg::QCF_COIL_OPEN;
        qcf_pkg::QCF_SS_LSHORT: coil_nxt = qcf_pkg::QCF_COIL_LSHRT;
        qcf_pkg::QCF_SS_HSHORT: coil_nxt = qcf_pkg::QCF_COIL_HSHRT;
        default:                coil_nxt = qcf_pkg::QCF_COIL_RUN;
      endcase
    end
  end
  wire use_ss = stand_r & ss_ok & (ssm_r != 2'h0);
  wire [7:0] cur_nxt = use_ss ? 8'h0 : stand_r ? stby_r : run_cur_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_on      <= 1'b0;
      pwm_freq      <= qcf_pkg::QCF_FREQ_RST;
      pwm_autoscale <= qcf_pkg::QCF_ASCL_RST;
      pwm_grad      <= qcf_pkg::QCF_GRAD_RST;
      coil_state    <= 2'h0;
      coil_cur_lim  <= 8'h0;
      standstill    <= 1'b0;
    end else begin
      quiet_on      <= quiet_r;
      pwm_freq      <= freq_r;
      pwm_autoscale <= ascl_r;
      pwm_grad      <= grad_r;
      coil_state    <= coil_nxt;
      coil_cur_lim  <= cur_nxt;
      standstill    <= stand_r;
    end
  end

  // checks
  property p_grad_zero;
    @(posedge pclk) disable iff (!presetn)
      (grad_r == 4'h0) |=> !quiet_r;
  endproperty
  a_grad_zero: assert property (p_grad_zero)
    else $error("quiet mode with zero gradient");

  property p_grad_max;
    @(posedge pclk) disable iff (!presetn)
      (wr_go && sel_grad && (pwdata[31:4] != 28'h0)) |=>
        grad_r == qcf_pkg::QCF_GRAD_MAX;
  endproperty
  a_grad_max: assert property (p_grad_max)
    else $error("gradient out of range");

  property p_thresh;
    @(posedge pclk) disable iff (!presetn)
      (reeval && (!below_cool || !below_pwm)) |=> !quiet_r;
  endproperty
  a_thresh: assert property (p_thresh)
    else $error("quiet mode above threshold");

  property p_fs;
    @(posedge pclk) disable iff (!presetn)
      (reeval && !below_fs) |=> !quiet_r;
  endproperty
  a_fs: assert property (p_fs)
    else $error("quiet mode above fullstep threshold");

  property p_follow;
    @(posedge pclk) disable iff (!presetn)
      reeval |=> (quiet_r == $past(quiet_nxt))
        ##1 (quiet_on == $past(quiet_r));
  endproperty
  a_follow: assert property (p_follow)
    else $error("mode did not follow speed");

  property p_status;
    @(posedge pclk) disable iff (!presetn)
      (wr_go && sel_sts) |=> $stable(quiet_r);
  endproperty
  a_status: assert property (p_status)
    else $error("status write changed flag");

  property p_freq;
    @(posedge pclk) disable iff (!presetn) ##1 pwm_freq == $past(freq_r);
  endproperty
  a_freq: assert property (p_freq)
    else $error("pwm frequency mismatch");

  property p_ss_gate;
    @(posedge pclk) disable iff (!presetn)
      (coil_state != 2'h0) |-> $past(ss_ok) && $past(stand_r);
  endproperty
  a_ss_gate: assert property (p_ss_gate)
    else $error("standstill mode without quiet and zero standby");

  property p_stby;
    @(posedge pclk) disable iff (!presetn)
      (stand_r && !use_ss) |=> coil_cur_lim == $past(stby_r);
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby current not applied");

  property p_move_clr;
    @(posedge pclk) disable iff (!presetn) moving |=> !stand_r;
  endproperty
  a_move_clr: assert property (p_move_clr)
    else $error("standstill while moving");

  property p_stand_tick;
    @(posedge pclk) disable iff (!presetn)
      $rose(stand_r) |-> $past(tick10);
  endproperty
  a_stand_tick: assert property (p_stand_tick)
    else $error("standstill outside a delay tick");

  property p_run_cur;
    @(posedge pclk) disable iff (!presetn)
      !stand_r |=> coil_cur_lim == $past(run_cur_r);
  endproperty
  a_run_cur: assert property (p_run_cur)
    else $error("current lowered before standstill");

  property p_open;
    @(posedge pclk) disable iff (!presetn)
      (stand_r && ss_ok && ssm_r == 2'h1) |=> coil_state == 2'h1;
  endproperty
  a_open: assert property (p_open)
    else $error("coils not opened at rest");

  property p_lshort;
    @(posedge pclk) disable iff (!presetn)
      (stand_r && ss_ok && ssm_r == 2'h2) |=> coil_state == 2'h2;
  endproperty
  a_lshort: assert property (p_lshort)
    else $error("low-side short missing at rest");

  property p_hshort;
    @(posedge pclk) disable iff (!presetn)
      (stand_r && ss_ok && ssm_r == 2'h3) |=> coil_state == 2'h3;
  endproperty
  a_hshort: assert property (p_hshort)
    else $error("high-side short missing at rest");

  property p_sts_rd;
    @(posedge pclk) disable iff (!presetn)
      (acc && !pready && !pwrite && sel_sts) |=>
        prdata == {30'h0, $past(stand_r), $past(quiet_r)};
  endproperty
  a_sts_rd: assert property (p_sts_rd)
    else $error("status read does not show mode");

  c_quiet: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(quiet_on));
  c_open: cover property (@(posedge pclk) disable iff (!presetn)
    coil_state == 2'h1);
  c_short: cover property (@(posedge pclk) disable iff (!presetn)
    coil_state == 2'h3);
  c_lshort: cover property (@(posedge pclk) disable iff (!presetn)
    coil_state == 2'h2);
  c_stand: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(standstill));
endmodule

//--- dv/qcf_stage_model.sv
`timescale 1ns/10ps
// behavioural power stage: turns the coil condition into bridge states
module qcf_stage_model (
  input  wire logic [1:0] coil_state,
  input  wire logic [7:0] coil_cur_lim,
  output logic            ls_short,
  output logic            hs_short,
  output logic            bridge_off,
  output logic      [7:0] coil_cur
);
  assign ls_short   = (coil_state == 2'h2);
  assign hs_short   = (coil_state == 2'h3);
  assign bridge_off = (coil_state != 2'h0);
  // any non-run state removes current, whatever the limit says
  assign coil_cur   = bridge_off ? 8'h00 : coil_cur_lim;
endmodule

//--- dv/qcf_select_tb.sv
`timescale 1ns/10ps
module qcf_select_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        quiet_on;
  logic [1:0]  pwm_freq;
  logic        pwm_autoscale;
  logic [3:0]  pwm_grad;
  logic [1:0]  coil_state;
  logic [7:0]  coil_cur_lim;
  logic        standstill;
  logic        ls_short;
  logic        hs_short;
  logic        bridge_off;
  logic [7:0]  coil_cur;
  int          n_errors;
  int          compares;
  logic [31:0] rd;
  logic        err;

  // short delay unit keeps the standstill test within a few hundred cycles
  qcf_select #(.PD_UNIT_CYC(200)) qcf_select_i (.pclk(pclk),
    .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .quiet_on(quiet_on), .pwm_freq(pwm_freq),
    .pwm_autoscale(pwm_autoscale), .pwm_grad(pwm_grad),
    .coil_state(coil_state), .coil_cur_lim(coil_cur_lim),
    .standstill(standstill));
  qcf_stage_model qcf_stage_model_i (.coil_state(coil_state),
    .coil_cur_lim(coil_cur_lim), .ls_short(ls_short),
    .hs_short(hs_short), .bridge_off(bridge_off), .coil_cur(coil_cur));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; pready and the answer are taken at the rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      n_errors++;
      conclude();
    end else begin
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // settle: re-evaluation plus output register
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (4) @(negedge pclk);
  endtask

  initial begin
    int i;
    n_errors = 0;
    compares = 0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(pwm_freq, 32'h1);
    chk(pwm_autoscale, 32'h1);
    chk(quiet_on, 32'h0);
    rchk(qcf_pkg::QCF_OFF_GRAD, 32'h0);
    rchk(qcf_pkg::QCF_OFF_FSTH, 32'h00ffffff);
    rchk(qcf_pkg::QCF_OFF_PWMCFG, 32'h5);
    rchk(qcf_pkg::QCF_OFF_PDDLY, 32'hc8);
    rchk(qcf_pkg::QCF_OFF_STBY, 32'hff00);
    apb(1'b0, 12'h024, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    $display("test reset done");
    // thresholds open, gradient still zero keeps quiet mode off
    wr(qcf_pkg::QCF_OFF_COOLTH, 32'd5000);
    wr(qcf_pkg::QCF_OFF_PWMTH, 32'd5000);
    wr(qcf_pkg::QCF_OFF_VEL, 32'd4999);
    chk(quiet_on, 32'h0);
    wr(qcf_pkg::QCF_OFF_GRAD, 32'h20);
    chk(pwm_grad, 32'hf);
    rchk(qcf_pkg::QCF_OFF_GRAD, 32'hf);
    chk(quiet_on, 32'h1);
    rchk(qcf_pkg::QCF_OFF_STATUS, 32'h1);
    wr(qcf_pkg::QCF_OFF_STATUS, 32'h0);
    rchk(qcf_pkg::QCF_OFF_STATUS, 32'h1);
    wr(qcf_pkg::QCF_OFF_VEL, 32'd5000);
    chk(quiet_on, 32'h0);
    wr(qcf_pkg::QCF_OFF_VEL, 32'hffffec79);
    chk(quiet_on, 32'h1);
    wr(qcf_pkg::QCF_OFF_VEL, 32'hffffec78);
    chk(quiet_on, 32'h0);
    wr(qcf_pkg::QCF_OFF_VEL, 32'd100);
    wr(qcf_pkg::QCF_OFF_COOLTH, 32'd100);
    chk(quiet_on, 32'h0);
    wr(qcf_pkg::QCF_OFF_COOLTH, 32'd101);
    chk(quiet_on, 32'h1);
    wr(qcf_pkg::QCF_OFF_FSTH, 32'd100);
    chk(quiet_on, 32'h0);
    wr(qcf_pkg::QCF_OFF_FSTH, 32'd101);
    chk(quiet_on, 32'h1);
    $display("test quiet select done");
    for (i = 0; i < 4; i++) begin
      wr(qcf_pkg::QCF_OFF_PWMCFG, 32'(i));
      chk(pwm_freq, 32'(i));
      chk(pwm_autoscale, 32'h0);
    end
    $display("test frequency done");
    // standstill: zero speed, delay of two units, standby current 0x10
    wr(qcf_pkg::QCF_OFF_PDDLY, 32'h2);
    wr(qcf_pkg::QCF_OFF_STBY, 32'hff10);
    wr(qcf_pkg::QCF_OFF_VEL, 32'h0);
    chk(standstill, 32'h0);
    chk(coil_cur, 32'hff);
    for (i = 0; i < 1000 && standstill !== 1'b1; i++) begin
      @(negedge pclk);
    end
    chk(standstill, 32'h1);
    chk(32'(i >= 300), 32'h1);
    chk(coil_state, 32'h0);
    chk(coil_cur, 32'h10);
    rchk(qcf_pkg::QCF_OFF_STATUS, 32'h3);
    wr(qcf_pkg::QCF_OFF_PWMCFG, 32'h11);
    chk(coil_state, 32'h0);
    chk(coil_cur, 32'h10);
    wr(qcf_pkg::QCF_OFF_STBY, 32'hff00);
    for (i = 1; i < 4; i++) begin
      wr(qcf_pkg::QCF_OFF_PWMCFG, 32'(i * 16));
      chk(coil_state, 32'(i));
      chk(bridge_off, 32'h1);
      chk(ls_short, 32'(i == 2));
      chk(hs_short, 32'(i == 3));
      chk(coil_cur_lim, 32'h0);
    end
    wr(qcf_pkg::QCF_OFF_GRAD, 32'h0);
    chk(quiet_on, 32'h0);
    chk(coil_state, 32'h0);
    wr(qcf_pkg::QCF_OFF_VEL, 32'd10);
    chk(standstill, 32'h0);
    chk(coil_cur, 32'hff);
    $display("test standstill done");
    conclude();
  end
endmodule
